// File: hbcds_params.svh
// Constants for the H-bridge control, diagnosis and serial block
`ifndef HBCDS_PARAMS_SVH
`define HBCDS_PARAMS_SVH

`define HBCDS_CLK_NS 20
`define HBCDS_T_BLANK_NS 6000
`define HBCDS_T_FILT_NS 2000
`define HBCDS_T_TRANS_NS 10000
`define HBCDS_BLANK_CYC ((`HBCDS_T_BLANK_NS + `HBCDS_CLK_NS - 1) / `HBCDS_CLK_NS)
`define HBCDS_FILT_CYC ((`HBCDS_T_FILT_NS + `HBCDS_CLK_NS - 1) / `HBCDS_CLK_NS)
`define HBCDS_TRANS_CYC ((`HBCDS_T_TRANS_NS + `HBCDS_CLK_NS - 1) / `HBCDS_CLK_NS)
`define HBCDS_OL_EVENTS 3'h5
`define HBCDS_FW_CLEAR 3'h5

`define HBCDS_FAULT_RESET 8'hDF
`define HBCDS_CTRL_RESET 5'h00
`define HBCDS_REV_TOP 4'h2
`define HBCDS_CODE_NONE 4'hF
`define HBCDS_CODE_OPEN 4'hC
`define HBCDS_CODE_UNDERV 4'h3

`define HBCDS_CTRL_PROBE_OFF 4
`define HBCDS_CTRL_SEL 3
`define HBCDS_CTRL_EN 2
`define HBCDS_CTRL_ROT 1
`define HBCDS_CTRL_DUTY 0

`define HBCDS_CMD_RD_FAULT 3'h0
`define HBCDS_CMD_CLR_FAULT 3'h4
`define HBCDS_CMD_RD_VER 3'h1
`define HBCDS_CMD_RD_CTRL 3'h3
`define HBCDS_CMD_WR_CTRL 3'h7
`define HBCDS_CMD_WR_RD_FAULT 3'h6

`define HBCDS_ADDR_STATUS 12'h000
`define HBCDS_ADDR_CLEAR 12'h004

`endif

// File: hbcds_pkg.sv
// Types shared by the H-bridge control, diagnosis and serial block
package hbcds_pkg;

	typedef struct packed {
		logic bridge_off_input;
		logic duty;
		logic rotation;
		logic sclk;
		logic frame_select_n;
		logic serial_in;
		logic logic_out_supply;
		logic [1:0] over_limit;
		logic [1:0] short_high;
		logic [1:0] short_low;
		logic overheat_trip;
		logic overheat_cool;
		logic undervoltage;
		logic leg_a_high;
		logic freewheel_seen;
	} hbcds_pin_s;

	typedef struct packed {
		logic high_switch_a;
		logic low_switch_a;
		logic high_switch_b;
		logic low_switch_b;
	} hbcds_gate_s;

	typedef enum logic [2:0] {
		HBCDS_SS_IDLE = 3'b001,
		HBCDS_SS_FLAG = 3'b010,
		HBCDS_SS_SHIFT = 3'b100
	} hbcds_ser_e;

	typedef enum logic [1:0] {
		HBCDS_RESP_VER = 2'h0,
		HBCDS_RESP_FAULT = 2'h1,
		HBCDS_RESP_CTRL = 2'h2
	} hbcds_resp_e;

endpackage : hbcds_pkg

// File: hbcds_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module hbcds_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] q_r;
	logic [W-1:0] agree;

	assign agree = ~(s2_r ^ s3_r);
	assign q = q_r;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			q_r <= '0;
		end else if (ce) begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q_r <= (agree & s3_r) | (~agree & q_r);
		end
	end
endmodule : hbcds_sync

// File: hbcds_top.sv
// H-bridge leg control, protection, diagnosis and serial slave
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "hbcds_params.svh"

module hbcds_top #(
	parameter int CW = 12,
	parameter logic [3:0] REV_CODE = 4'h1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Pins and analog indications
	input wire hbcds_pkg::hbcds_pin_s pins,
	// Switch gates and probe
	output hbcds_pkg::hbcds_gate_s gate,
	output logic probe_on,
	// Serial output
	output logic serial_out,
	output logic serial_out_oe
);
	import hbcds_pkg::*;

	// REV_CODE default is arbitrary

	// ****************************************
	// Input synchronisation
	// ****************************************
	// Select idles high: sync resets to idle, no false frame
	localparam hbcds_pin_s PIN_IDLE = '{frame_select_n: 1'b1, default: '0};

	hbcds_pin_s ps;
	logic [$bits(hbcds_pin_s)-1:0] ps_bits;
	logic [$bits(hbcds_pin_s)-1:0] sync_in;

	assign sync_in = pins ^ PIN_IDLE;

	hbcds_sync #(.W($bits(hbcds_pin_s))) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.ce(ce),
		.d(sync_in),
		.q(ps_bits)
	);
	assign ps = hbcds_pin_s'(ps_bits ^ PIN_IDLE);

	// ****************************************
	// State
	// ****************************************
	hbcds_gate_s gate_r;
	hbcds_gate_s gate_nxt;
	logic probe_r;
	logic [4:0] ctrl_r;
	logic [2:0] ctrl_cmd_r;
	logic [2:0] pin_prev_r;
	logic off_prev_r;
	logic rot_prev_r;
	logic duty_prev_r;
	logic sclk_prev_r;
	logic sel_prev_r;
	logic [3:0] short_r;
	logic [CW-1:0] short_cnt_r [4];
	logic [1:0] chop_r;
	logic [CW-1:0] lim_cnt_r [2];
	logic [CW-1:0] trans_cnt_r [2];
	logic cl_flag_r;
	logic ot_r;
	logic fw_phase_r;
	logic [2:0] ol_cnt_r;
	logic [2:0] fw_cnt_r;
	hbcds_ser_e ser_r;
	hbcds_resp_e resp_r;
	logic [7:0] tx_r;
	logic [7:0] rx_r;
	logic so_r;
	logic so_oe_r;
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;

	// ****************************************
	// Effective control
	// ****************************************
	logic [2:0] pin_now;
	logic pins_zero;
	logic pin_chg;
	logic ser_drive;
	logic off_eff;
	logic duty_eff;
	logic rot_eff;
	logic stop_all;
	logic fault_flag;
	logic off_rise;
	logic rot_chg;
	logic probe_off;

	assign pin_now = {ps.bridge_off_input, ps.duty, ps.rotation};
	assign pins_zero = (pin_now == 3'h0);
	assign pin_chg = (pin_now != pin_prev_r);
	assign ser_drive = ctrl_r[`HBCDS_CTRL_SEL];
	assign probe_off = ctrl_r[`HBCDS_CTRL_PROBE_OFF];
	assign off_eff = ser_drive ? ~ctrl_r[`HBCDS_CTRL_EN] : ps.bridge_off_input;
	assign duty_eff = ser_drive ? ctrl_r[`HBCDS_CTRL_DUTY] : ps.duty;
	assign rot_eff = ser_drive ? ctrl_r[`HBCDS_CTRL_ROT] : ps.rotation;
	assign off_rise = off_eff & ~off_prev_r;
	assign rot_chg = rot_eff ^ rot_prev_r;
	assign stop_all = off_eff | (|short_r) | ot_r | ps.undervoltage | ~ps.logic_out_supply;
	assign fault_flag = stop_all;

	// ****************************************
	// Leg decode
	// ****************************************
	always_comb begin
		gate_nxt.high_switch_a = ~stop_all & rot_eff;
		gate_nxt.high_switch_b = ~stop_all & ~rot_eff;
		gate_nxt.low_switch_b = ~stop_all & duty_eff & rot_eff & ~chop_r[0];
		gate_nxt.low_switch_a = ~stop_all & duty_eff & ~rot_eff & ~chop_r[1];
	end

	// ****************************************
	// Short detection
	// ****************************************
	logic [3:0] sw_on;
	logic [3:0] short_in;
	logic [3:0] short_set;
	logic fault_clr;
	logic cmd_clr;
	logic apb_clr;

	assign sw_on = {gate_r.low_switch_b, gate_r.low_switch_a, gate_r.high_switch_b, gate_r.high_switch_a};
	assign short_in = {ps.short_low, ps.short_high};
	assign fault_clr = cmd_clr | apb_clr | off_rise | ~ps.logic_out_supply;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_short
			logic hit;
			assign hit = short_in[gi] & sw_on[gi];
			assign short_set[gi] = hit && (short_cnt_r[gi] >= CW'(`HBCDS_FILT_CYC - 1));
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					short_cnt_r[gi] <= '0;
					short_r[gi] <= 1'b0;
				end else if (ce) begin
					short_cnt_r[gi] <= hit ? short_cnt_r[gi] + CW'(1) : '0;
					short_r[gi] <= short_set[gi] | (short_r[gi] & ~fault_clr);
				end
			end
		end
	endgenerate

	// ****************************************
	// Chopper current limit
	// ****************************************
	logic [1:0] hs_on;

	assign hs_on = {gate_r.high_switch_b, gate_r.high_switch_a};

	generate
		for (gi = 0; gi < 2; gi++) begin : g_chop
			logic over;
			logic want;
			logic move;
			assign over = ps.over_limit[gi] & hs_on[gi];
			assign want = over && (lim_cnt_r[gi] >= CW'(`HBCDS_BLANK_CYC));
			assign move = (want != chop_r[gi]) && (trans_cnt_r[gi] == '0);
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					lim_cnt_r[gi] <= '0;
					trans_cnt_r[gi] <= '0;
					chop_r[gi] <= 1'b0;
				end else if (ce) begin
					if (!over) begin
						lim_cnt_r[gi] <= '0;
					end else if (lim_cnt_r[gi] < CW'(`HBCDS_BLANK_CYC)) begin
						lim_cnt_r[gi] <= lim_cnt_r[gi] + CW'(1);
					end
					if (move) begin
						chop_r[gi] <= want;
						trans_cnt_r[gi] <= CW'(`HBCDS_TRANS_CYC - 1);
					end else if (trans_cnt_r[gi] != '0) begin
						trans_cnt_r[gi] <= trans_cnt_r[gi] - CW'(1);
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Open load in on and off state
	// ****************************************
	logic duty_rise;
	logic duty_fall;
	logic switching;
	logic ol_on;
	logic ol_off;

	assign switching = ~stop_all;
	assign duty_rise = switching & duty_eff & ~duty_prev_r;
	assign duty_fall = switching & ~duty_eff & duty_prev_r;
	assign ol_on = (ol_cnt_r >= `HBCDS_OL_EVENTS);
	assign ol_off = off_eff & probe_r & ps.leg_a_high;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			fw_phase_r <= 1'b0;
			ol_cnt_r <= 3'h0;
			fw_cnt_r <= 3'h0;
		end else if (ce) begin
			if (duty_fall) begin
				fw_phase_r <= 1'b0;
			end else if (!duty_eff && ps.freewheel_seen) begin
				fw_phase_r <= 1'b1;
			end
			if (rot_chg || !switching) begin
				ol_cnt_r <= 3'h0;
				fw_cnt_r <= 3'h0;
			end else if (duty_rise && !fw_phase_r) begin
				ol_cnt_r <= ol_on ? ol_cnt_r : ol_cnt_r + 3'h1;
				fw_cnt_r <= 3'h0;
			end else if (duty_rise) begin
				fw_cnt_r <= (fw_cnt_r >= `HBCDS_FW_CLEAR - 3'h1) ? 3'h0 : fw_cnt_r + 3'h1;
				if (fw_cnt_r >= `HBCDS_FW_CLEAR - 3'h1) begin
					ol_cnt_r <= 3'h0;
				end
			end
		end
	end

	// ****************************************
	// Fault byte
	// ****************************************
	function automatic logic [7:0] fault_byte_f(input logic en, input logic ot, input logic cl,
		input logic [3:0] sc, input logic uv, input logic ol);
		logic [3:0] code;
		code = `HBCDS_CODE_NONE;
		if (|sc) begin
			code = ~{sc[3], sc[1], sc[2], sc[0]};
		end else if (uv) begin
			code = `HBCDS_CODE_UNDERV;
		end else if (ol) begin
			code = `HBCDS_CODE_OPEN;
		end
		fault_byte_f = {en, ~ot, 1'b0, ~cl, code};
	endfunction : fault_byte_f

	logic [7:0] fault_byte;
	logic ol_any;

	assign ol_any = ~probe_off & (ol_off | (~off_eff & ol_on));
	assign fault_byte = fault_byte_f(~off_eff, ot_r, cl_flag_r, short_r, ps.undervoltage, ol_any);

	// ****************************************
	// Serial slave
	// ****************************************
	logic sel_fall;
	logic sel_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic [2:0] cmd;
	logic [7:0] resp_byte;
	logic frame_end;

	assign sel_fall = ~ps.frame_select_n & sel_prev_r;
	assign sel_rise = ps.frame_select_n & ~sel_prev_r;
	assign sclk_rise = ps.sclk & ~sclk_prev_r;
	assign sclk_fall = ~ps.sclk & sclk_prev_r;
	assign frame_end = sel_rise && (ser_r != HBCDS_SS_IDLE);
	assign cmd = rx_r[7:5];
	assign cmd_clr = frame_end && (cmd == `HBCDS_CMD_CLR_FAULT);
	assign resp_byte = (resp_r == HBCDS_RESP_VER) ? {`HBCDS_REV_TOP, REV_CODE} :
		(resp_r == HBCDS_RESP_CTRL) ? {ctrl_cmd_r, ctrl_r} : fault_byte;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ser_r <= HBCDS_SS_IDLE;
			tx_r <= 8'h00;
			rx_r <= 8'h00;
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else if (ce) begin
			if (sel_fall) begin
				ser_r <= HBCDS_SS_FLAG;
				tx_r <= resp_byte;
				so_oe_r <= 1'b1;
				so_r <= fault_flag | ps.serial_in;
			end else begin
				unique case (ser_r)
					HBCDS_SS_IDLE: begin
						so_oe_r <= 1'b0;
					end
					HBCDS_SS_FLAG: begin
						if (sclk_rise) begin
							so_r <= tx_r[7];
							tx_r <= {tx_r[6:0], 1'b0};
							ser_r <= HBCDS_SS_SHIFT;
						end else begin
							so_r <= fault_flag | ps.serial_in;
						end
					end
					HBCDS_SS_SHIFT: begin
						if (sclk_rise) begin
							so_r <= tx_r[7];
							tx_r <= {tx_r[6:0], rx_r[0]};
						end
					end
				endcase
				if (sclk_fall && ser_r != HBCDS_SS_IDLE) begin
					rx_r <= {rx_r[6:0], ps.serial_in};
				end
				if (frame_end) begin
					ser_r <= HBCDS_SS_IDLE;
					so_oe_r <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Command execution and control
	// ****************************************
	logic wr_ctrl;

	assign wr_ctrl = frame_end && (cmd == `HBCDS_CMD_WR_CTRL || cmd == `HBCDS_CMD_WR_RD_FAULT);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			resp_r <= HBCDS_RESP_VER;
			ctrl_r <= `HBCDS_CTRL_RESET;
			ctrl_cmd_r <= 3'h0;
		end else if (ce) begin
			if (frame_end) begin
				unique case (cmd)
					`HBCDS_CMD_RD_VER: resp_r <= HBCDS_RESP_VER;
					`HBCDS_CMD_RD_CTRL, `HBCDS_CMD_WR_CTRL: resp_r <= HBCDS_RESP_CTRL;
					default: resp_r <= HBCDS_RESP_FAULT;
				endcase
			end
			if (wr_ctrl) begin
				ctrl_cmd_r <= cmd;
			end
			if (pin_chg) begin
				ctrl_r[`HBCDS_CTRL_SEL] <= 1'b0;
			end else if (wr_ctrl) begin
				ctrl_r <= {rx_r[4], rx_r[3] & pins_zero, rx_r[2:0]};
			end
			if (pin_chg && wr_ctrl) begin
				ctrl_r[4] <= rx_r[4];
				ctrl_r[2:0] <= rx_r[2:0];
			end
		end
	end

	// ****************************************
	// Protection flags and outputs
	// ****************************************
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			gate_r <= '0;
			probe_r <= 1'b0;
			ot_r <= 1'b0;
			cl_flag_r <= 1'b0;
			pin_prev_r <= 3'h0;
			off_prev_r <= 1'b0;
			rot_prev_r <= 1'b0;
			duty_prev_r <= 1'b0;
			sclk_prev_r <= 1'b0;
			sel_prev_r <= 1'b1;
		end else if (ce) begin
			gate_r <= gate_nxt;
			probe_r <= off_eff & ~probe_off;
			ot_r <= ps.overheat_trip | (ot_r & ~ps.overheat_cool);
			cl_flag_r <= (|chop_r) | (cl_flag_r & ~rot_chg);
			pin_prev_r <= pin_now;
			off_prev_r <= off_eff;
			rot_prev_r <= rot_eff;
			duty_prev_r <= duty_eff;
			sclk_prev_r <= ps.sclk;
			sel_prev_r <= ps.frame_select_n;
		end
	end

	assign gate = gate_r;
	assign probe_on = probe_r;
	assign serial_out = so_r;
	assign serial_out_oe = so_oe_r;

	// ****************************************
	// APB slave
	// ****************************************
	logic apb_setup;
	logic apb_done;
	logic addr_status;
	logic addr_clear;

	assign apb_setup = psel & ~penable;
	assign apb_done = psel & penable & pready_r;
	assign addr_status = (paddr == `HBCDS_ADDR_STATUS);
	assign addr_clear = (paddr == `HBCDS_ADDR_CLEAR);
	assign apb_clr = apb_done & pwrite & addr_clear & pwdata[0];

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			pready_r <= apb_setup;
			if (apb_setup) begin
				pslverr_r <= ~(addr_status | addr_clear) | (pwrite & addr_status);
				prdata_r <= (!pwrite && addr_status) ?
					{8'h00, sw_on, ser_r == HBCDS_SS_IDLE, ot_r, |chop_r, ser_drive, ctrl_cmd_r, ctrl_r, fault_byte} :
					32'h0000_0000;
			end else if (apb_done) begin
				pslverr_r <= 1'b0;
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign prdata = prdata_r;
endmodule : hbcds_top

// File: hbcds_props.sv
// Port-level assertions for the H-bridge control block
`timescale 1ns/1ps
module hbcds_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Pins and outputs
	input wire hbcds_pkg::hbcds_pin_s pins,
	input wire hbcds_pkg::hbcds_gate_s gate,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	import hbcds_pkg::*;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// ****************************************
	// Sequences
	// ****************************************
	sequence s_flag_phase;
		$fell(pins.frame_select_n) ##1 (!pins.frame_select_n && !pins.sclk && pins.serial_in) [*8];
	endsequence
	sequence s_fw_fwd;
		(!pins.bridge_off_input && !pins.duty && pins.rotation && !pins.undervoltage
			&& !pins.overheat_trip && pins.logic_out_supply) [*8];
	endsequence
	// Own short flagged whichever high or low switch is on
	property p_short(logic hit, logic sw);
		($rose(hit) && sw) ##1 (hit throughout ##120 1'b1) |-> gate == 4'h0;
	endproperty

	// ****************************************
	// Assertions
	// ****************************************
	chk_off_all_open: assert property (pins.bridge_off_input [*8] |-> gate == 4'h0)
		else $error("Gate on while bridge off");
	chk_heat_all_off: assert property (pins.overheat_trip [*8] |-> gate == 4'h0)
		else $error("Gate on during overheat");
	chk_uv_all_off: assert property (pins.undervoltage [*8] |-> gate == 4'h0)
		else $error("Gate on during undervoltage");
	chk_freewheel_high: assert property (s_fw_fwd ##0 gate != 4'h0 |-> gate == 4'b1000)
		else $error("Wrong freewheel pattern");
	chk_short_ground: assert property (p_short(&pins.short_high, gate.high_switch_a | gate.high_switch_b))
		else $error("High-side short did not shut off");
	chk_short_supply: assert property (p_short(&pins.short_low, gate.low_switch_a | gate.low_switch_b))
		else $error("Low-side short did not shut off");
	chk_frame_opens: assert property ($fell(pins.frame_select_n) ##1 !pins.frame_select_n [*7] |-> serial_out_oe)
		else $error("Output not driven in frame");
	chk_frame_closes: assert property ($rose(pins.frame_select_n) ##1 pins.frame_select_n [*7] |-> !serial_out_oe)
		else $error("Output driven after frame");
	chk_flag_or_input: assert property (s_flag_phase |-> serial_out)
		else $error("Serial input not ORed onto output");
	chk_flag_on_stop: assert property ($fell(pins.frame_select_n) ##1
		(!pins.frame_select_n && !pins.sclk && pins.bridge_off_input) [*8] |-> serial_out)
		else $error("Fault flag missing while bridge off");
endmodule : hbcds_props

bind hbcds_top hbcds_props u_props (.sys_clk(sys_clk), .resetn(resetn), .pins(pins), .gate(gate),
	.serial_out(serial_out), .serial_out_oe(serial_out_oe));

// File: hbcds_spi_master.sv
// Serial bus master model for the H-bridge block
`timescale 1ns/1ps
module hbcds_spi_master (
	// Serial lines
	output logic sclk,
	output logic frame_select_n,
	output logic serial_in,
	input wire logic serial_out
);
	initial begin
		sclk = 1'b0;
		frame_select_n = 1'b1;
		serial_in = 1'b0;
	end

	// ****************************************
	// One frame, clock still outside it
	// ****************************************
	task automatic xfer(input logic [7:0] cmd, output logic [7:0] resp);
		#7;
		serial_in = cmd[7];
		frame_select_n = 1'b0;
		#240;
		for (int i = 7; i >= 0; i--) begin
			sclk = 1'b1;
			if (i < 7) begin
				serial_in = cmd[i];
			end
			#80;
			sclk = 1'b0;
			#75;
			resp[i] = serial_out;
			#5;
		end
		frame_select_n = 1'b1;
		serial_in = ~serial_in;
		#240;
	endtask : xfer
endmodule : hbcds_spi_master

// File: testbench.sv
// Self-checking bench for the H-bridge control block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
	import hbcds_pkg::*;
	// Arbitrary version code
	localparam logic [3:0] REV = 4'h6;
	logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	hbcds_pin_s p, pins;
	hbcds_gate_s gate;
	logic probe_on, serial_out, serial_out_oe, m_sclk, m_sel_n, m_si;
	logic [7:0] rsp;
	int errors = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [7:0] cmds [8] = '{8'h00, 8'h20, 8'hF0, 8'h60, 8'h40, 8'h80, 8'hC0, 8'h00};
	logic [7:0] exps [8] = '{{4'h2, REV}, 8'hDF, {4'h2, REV}, 8'hF0, 8'hF0, 8'hDF, 8'hDF, 8'hDF};
	logic [2:0] tt_in [5] = '{3'b100, 3'b001, 3'b000, 3'b010, 3'b011};
	logic [3:0] tt_gate [5] = '{4'h0, 4'b1000, 4'b0010, 4'b0110, 4'b1001};

	always_comb begin
		pins = p;
		pins.sclk = m_sclk;
		pins.frame_select_n = m_sel_n;
		pins.serial_in = m_si;
	end

	hbcds_top #(.REV_CODE(REV)) u_hbcds_top (.sys_clk(sys_clk), .resetn(resetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .pins(pins), .gate(gate), .probe_on(probe_on),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));
	hbcds_spi_master u_master (.sclk(m_sclk), .frame_select_n(m_sel_n), .serial_in(m_si),
		.serial_out(serial_out));

	// ****************************************
	// Clock, timeout, tasks
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			stop_test();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rs();
		apb(1'b0, 12'h000, 32'h0);
	endtask : rs
	task automatic gt(input logic [3:0] e);
		repeat (12) @(posedge sys_clk);
		`CHK(gate, e)
	endtask : gt
	task automatic pin3(input logic [2:0] v);
		@(posedge sys_clk);
		{p.bridge_off_input, p.duty, p.rotation} <= v;
	endtask : pin3
	task automatic pulse(input int n, input logic fw);
		repeat (n) begin
			p.duty <= 1'b0;
			p.freewheel_seen <= fw;
			repeat (10) @(posedge sys_clk);
			p.duty <= 1'b1;
			repeat (10) @(posedge sys_clk);
		end
	endtask : pulse
	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		p = '0;
		p.logic_out_supply = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		resetn = 1'b0;
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (8) @(posedge sys_clk);
		rs();
		`CHK(rd[7:0], 8'hDF)
		apb(1'b0, 12'h008, 32'h0);
		`CHK(err, 1'b1)
		foreach (cmds[i]) begin
			u_master.xfer(cmds[i], rsp);
			`CHK(rsp, exps[i])
		end
		for (int i = 0; i < 5; i++) begin
			pin3(tt_in[i]);
			gt(tt_gate[i]);
		end
		p.over_limit <= 2'b11;
		repeat (320) @(posedge sys_clk);
		gt(4'b1000);
		rs();
		`CHK(rd[4], 1'b0)
		p.over_limit <= 2'b00;
		gt(4'b1000);
		repeat (500) @(posedge sys_clk);
		gt(4'b1001);
		pin3(3'b010);
		gt(4'b0110);
		rs();
		`CHK(rd[4], 1'b1)
		pin3(3'b011);
		for (int i = 0; i < 2; i++) begin
			{p.short_high, p.short_low} <= i ? 4'h3 : 4'hC;
			repeat (130) @(posedge sys_clk);
			{p.short_high, p.short_low} <= 4'h0;
			gt(4'h0);
			rs();
			`CHK(rd[3:0], i ? 4'h7 : 4'hE)
			if (i == 0) begin
				pin3(3'b111);
				repeat (8) @(posedge sys_clk);
				pin3(3'b011);
			end else begin
				apb(1'b1, 12'h004, 32'h1);
			end
			gt(4'b1001);
		end
		p.undervoltage <= 1'b1;
		gt(4'h0);
		rs();
		`CHK(rd[3:0], 4'h3)
		p.undervoltage <= 1'b0;
		gt(4'b1001);
		p.overheat_trip <= 1'b1;
		gt(4'h0);
		p.overheat_trip <= 1'b0;
		gt(4'h0);
		rs();
		`CHK(rd[6], 1'b0)
		p.overheat_cool <= 1'b1;
		gt(4'b1001);
		pulse(4, 1'b0);
		rs();
		`CHK(rd[3:0], 4'hF)
		pulse(2, 1'b0);
		rs();
		`CHK(rd[3:0], 4'hC)
		pulse(6, 1'b1);
		rs();
		`CHK(rd[3:0], 4'hF)
		p.leg_a_high <= 1'b1;
		pin3(3'b100);
		rs();
		gt(4'h0);
		`CHK(probe_on, 1'b1)
		rs();
		`CHK(rd[7:0], 8'h5C)
		u_master.xfer(8'hF0, rsp);
		`CHK(probe_on, 1'b0)
		rs();
		`CHK(rd[7:0], 8'h5F)
		pin3(3'b000);
		gt(4'b0010);
		u_master.xfer(8'hEF, rsp);
		`CHK(rsp, 8'hF0)
		gt(4'b1001);
		pin3(3'b001);
		gt(4'b1000);
		stop_test();
	end
endmodule : testbench
